// ==== output_onoff_delay_map.svh ====
// Register offsets, widths, reset values and timing for the output delay block
// How it works
// R1: Each output delays on, off, or both
// R2: Delay 0.1 to 100.0 s in tenths
// R3: Output asserts after full ON delay
// R4: Source pulses shorter than ON delay vanish
// R5: OFF delay extends trailing edge
// R6: Gaps shorter than OFF delay bridged
// R7: Both delays apply together
// R8: All six delays reset to zero
// R9: Delays apply to any assigned function
// R10: Function 00 drives output in Run
// R11: Run-status output off in Stop
// R12: Run-status output active low, sinks current; code: terminals 11 and 12 only, relay coil driven high
// R13: Run-status assignable to any output
// R14: Tenth-second tick counters restart on return
// R15: Outputs off, counters cleared after reset
`ifndef OUTPUT_ONOFF_DELAY_MAP_SVH
`define OUTPUT_ONOFF_DELAY_MAP_SVH

`define OOD_ADDR_W      6
`define OOD_DLY_W       11
`define OOD_FSEL_W      6
`define OOD_NCH         3
`define OOD_NDLY        6
`define OOD_SUB_W       32

`define OOD_REG_ON11    6'h00
`define OOD_REG_STRIDE  6'h04
`define OOD_REG_F11     6'h18
`define OOD_REG_STATUS  6'h24

`define OOD_DLY_MAX     11'h3E8
`define OOD_DLY_RST     11'h000
`define OOD_FSEL_RST    6'h00
`define OOD_FUNC_RUN    6'h00

`define OOD_TICK_MS     100
`define OOD_CLK_KHZ     125000

`endif

// ==== output_onoff_delay_pkg.sv ====
// Types shared by the output delay block
`default_nettype none
`include "output_onoff_delay_map.svh"

package output_onoff_delay_pkg;

    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`OOD_ADDR_W-1:0]    addr;
        logic [31:0]               wdata;
    } bus_req_t;

    typedef struct packed {
        logic                      level;
        logic [`OOD_DLY_W-1:0]     ticks;
        logic [`OOD_SUB_W-1:0]     sub;
    } chan_t;

    typedef struct packed {
        logic                      term11_out;
        logic                      term11_oe_n;
        logic                      term12_out;
        logic                      term12_oe_n;
        logic                      relay_coil;
    } pins_t;

    typedef struct packed {
        chan_t [`OOD_NCH-1:0]                        ch;
        logic  [`OOD_NDLY-1:0][`OOD_DLY_W-1:0]       dly;
        logic  [`OOD_NCH-1:0][`OOD_FSEL_W-1:0]       fsel;
        logic  [31:0]                                rdata;
        pins_t                                       pins;
    } state_t;

endpackage : output_onoff_delay_pkg

`default_nettype wire

// ==== output_onoff_delay.sv ====
// Output ON/OFF delay and function routing for terminals 11, 12 and the relay
//
// Design decisions made here: strobed register access and the register offsets.
`default_nettype none
`include "output_onoff_delay_map.svh"

module output_onoff_delay #(
    parameter int unsigned FUNC_N      = 64,
    parameter int unsigned TICK_CYCLES = `OOD_TICK_MS * `OOD_CLK_KHZ
) (
    input  wire logic                             clock_i,
    input  wire logic                             sys_rst_i,
    input  wire output_onoff_delay_pkg::bus_req_t bus_i,
    output var  logic [31:0]                      rdata_o,
    input  wire logic                             run_mode_i,
    input  wire logic [FUNC_N-1:0]                func_src_i,
    output var  logic                             term11_out_o,
    output var  logic                             term11_oe_n_o,
    output var  logic                             term12_out_o,
    output var  logic                             term12_oe_n_o,
    output var  logic                             relay_coil_o
);
    import output_onoff_delay_pkg::*;

    localparam logic [`OOD_SUB_W-1:0] TICK_LAST = `OOD_SUB_W'(TICK_CYCLES - 1);

    state_t state;
    state_t next_state;

    // Function code 00 is the run signal; other codes pick a source line
    function automatic logic pick_source(
        input logic [`OOD_FSEL_W-1:0] code,
        input logic                   run,
        input logic [FUNC_N-1:0]      src
    );
        logic hit;
        hit = 1'b0;
        // R10 R11 R13 run-status routing
        if (code == `OOD_FUNC_RUN) begin
            hit = run;
        end else if (int'(code) < FUNC_N) begin
            hit = src[code];
        end
        return hit;
    endfunction : pick_source

    // Values above 100.0 s are held at the limit
    function automatic logic [`OOD_DLY_W-1:0] clamp_delay(input logic [31:0] value);
        logic [`OOD_DLY_W-1:0] res;
        res = `OOD_DLY_MAX;
        // R2 delay range
        if (value < 32'(`OOD_DLY_MAX)) begin
            res = value[`OOD_DLY_W-1:0];
        end
        return res;
    endfunction : clamp_delay

    function automatic logic [`OOD_ADDR_W-1:0] reg_addr(
        input logic [`OOD_ADDR_W-1:0] base,
        input int                     idx
    );
        return base + `OOD_ADDR_W'(idx) * `OOD_REG_STRIDE;
    endfunction : reg_addr

    always_comb begin
        logic [`OOD_NCH-1:0]   src;
        logic [`OOD_DLY_W-1:0] dly;
        next_state       = state;
        next_state.rdata = '0;
        src              = '0;
        dly              = '0;

        // R9 delays apply after any function choice
        for (int c = 0; c < `OOD_NCH; c++) begin
            src[c] = pick_source(state.fsel[c], run_mode_i, func_src_i);
        end

        if (bus_i.wr) begin
            for (int i = 0; i < `OOD_NDLY; i++) begin
                if (bus_i.addr == reg_addr(`OOD_REG_ON11, i)) begin
                    next_state.dly[i] = clamp_delay(bus_i.wdata);
                end
            end
            for (int c = 0; c < `OOD_NCH; c++) begin
                if (bus_i.addr == reg_addr(`OOD_REG_F11, c)) begin
                    next_state.fsel[c] = bus_i.wdata[`OOD_FSEL_W-1:0];
                end
            end
        end

        if (bus_i.rd) begin
            for (int i = 0; i < `OOD_NDLY; i++) begin
                if (bus_i.addr == reg_addr(`OOD_REG_ON11, i)) begin
                    next_state.rdata = 32'(state.dly[i]);
                end
            end
            for (int c = 0; c < `OOD_NCH; c++) begin
                if (bus_i.addr == reg_addr(`OOD_REG_F11, c)) begin
                    next_state.rdata = 32'(state.fsel[c]);
                end
            end
            if (bus_i.addr == `OOD_REG_STATUS) begin
                next_state.rdata = 32'({run_mode_i, src,
                    state.ch[2].level, state.ch[1].level, state.ch[0].level});
            end
        end

        for (int c = 0; c < `OOD_NCH; c++) begin
            // R1 R7 delay picked by the edge pending
            dly = state.ch[c].level ? state.dly[2*c+1] : state.dly[2*c];
            if (src[c] == state.ch[c].level) begin
                // R4 R6 R14 restart on return
                next_state.ch[c].ticks = '0;
                next_state.ch[c].sub   = '0;
            end else if (dly == '0) begin
                // R8 zero delay follows source
                next_state.ch[c].level = src[c];
                next_state.ch[c].ticks = '0;
                next_state.ch[c].sub   = '0;
            end else if (state.ch[c].sub == TICK_LAST) begin
                next_state.ch[c].sub = '0;
                // R3 R5 R14 full tick count
                if (state.ch[c].ticks + `OOD_DLY_W'(1) >= dly) begin
                    next_state.ch[c].level = src[c];
                    next_state.ch[c].ticks = '0;
                end else begin
                    next_state.ch[c].ticks = state.ch[c].ticks + `OOD_DLY_W'(1);
                end
            end else begin
                next_state.ch[c].sub = state.ch[c].sub + `OOD_SUB_W'(1);
            end
        end

        // R12 open collectors 11 and 12 sink when ON; relay coil driven high when ON
        next_state.pins.term11_out  = 1'b0;
        next_state.pins.term11_oe_n = ~next_state.ch[0].level;
        next_state.pins.term12_out  = 1'b0;
        next_state.pins.term12_oe_n = ~next_state.ch[1].level;
        next_state.pins.relay_coil  = next_state.ch[2].level;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            // R15 outputs off, counters clear
            state                  <= '0;
            state.pins.term11_oe_n <= 1'b1;
            state.pins.term12_oe_n <= 1'b1;
            for (int i = 0; i < `OOD_NDLY; i++) begin
                state.dly[i] <= `OOD_DLY_RST;
            end
            for (int c = 0; c < `OOD_NCH; c++) begin
                state.fsel[c] <= `OOD_FSEL_RST;
            end
        end else begin
            state <= next_state;
        end
    end

    assign rdata_o       = state.rdata;
    assign term11_out_o  = state.pins.term11_out;
    assign term11_oe_n_o = state.pins.term11_oe_n;
    assign term12_out_o  = state.pins.term12_out;
    assign term12_oe_n_o = state.pins.term12_oe_n;
    assign relay_coil_o  = state.pins.relay_coil;

endmodule : output_onoff_delay

`default_nettype wire

// ==== ood_props.sv ====
// Checker for the output delay block ports
`default_nettype none
module ood_props #(
    parameter int unsigned FUNC_N = 64
) (
    input wire logic                             clock_i,
    input wire logic                             sys_rst_i,
    input wire output_onoff_delay_pkg::bus_req_t bus_i,
    input wire logic [31:0]                      rdata_o,
    input wire logic                             run_mode_i,
    input wire logic [FUNC_N-1:0]                func_src_i,
    input wire logic                             term11_out_o,
    input wire logic                             term11_oe_n_o,
    input wire logic                             term12_out_o,
    input wire logic                             term12_oe_n_o,
    input wire logic                             relay_coil_o
);
    logic [2:0][5:0] sel;
    logic [2:0]      src;
    // Shadow of the selects, so sources are known here
    always_ff @(posedge clock_i)
        if (sys_rst_i)
            sel <= '0;
        else if (bus_i.wr && bus_i.addr >= 6'h18 && bus_i.addr <= 6'h20)
            sel[(bus_i.addr - 6'h18) >> 2] <= bus_i.wdata[5:0];
    always_comb
        for (int k = 0; k < 3; k++)
            src[k] = (sel[k] == 6'h00) ? run_mode_i : func_src_i[sel[k]];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    reset_off_a: assert property ($past(sys_rst_i) |-> term11_oe_n_o && term12_oe_n_o && !relay_coil_o) else $error("output on after reset");
    sink_only_a: assert property (!term11_out_o && !term12_out_o) else $error("terminal driven high");
    t11_on_a: assert property ($fell(term11_oe_n_o) |-> $past(src[0])) else $error("on without source");
    t11_off_a: assert property ($rose(term11_oe_n_o) |-> !$past(src[0])) else $error("off while source on");
    t12_on_a: assert property ($fell(term12_oe_n_o) |-> $past(src[1])) else $error("on without source");
    t12_off_a: assert property ($rose(term12_oe_n_o) |-> !$past(src[1])) else $error("off while source on");
    relay_on_a: assert property ($rose(relay_coil_o) |-> $past(src[2])) else $error("coil without source");
    relay_off_a: assert property ($fell(relay_coil_o) |-> !$past(src[2])) else $error("coil drop early");
    run_bit_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 6'h24 |-> rdata_o[6] == $past(run_mode_i)) else $error("run bit wrong");
endmodule : ood_props
bind output_onoff_delay ood_props #(.FUNC_N(FUNC_N)) props (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .run_mode_i(run_mode_i),
    .func_src_i(func_src_i), .term11_out_o(term11_out_o), .term11_oe_n_o(term11_oe_n_o),
    .term12_out_o(term12_out_o), .term12_oe_n_o(term12_oe_n_o), .relay_coil_o(relay_coil_o));
`default_nettype wire

// ==== ext_loads.sv ====
// Loads wired to the two transistors and the relay coil
`default_nettype none
module ext_loads (
    input  wire logic       oc11_i,
    input  wire logic       oc12_i,
    input  wire logic       coil_i,
    output var  logic [2:0] on_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_comb on_o = {coil_i, ~oc12_i, ~oc11_i};
endmodule : ext_loads
`default_nettype wire

// ==== tb_top.sv ====
// Bench for the output delay block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import output_onoff_delay_pkg::*;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        run_mode_i = 1'b0;
    bus_req_t    bus_i = '0;
    logic [63:0] func_src_i = '0;
    logic [31:0] rdata_o;
    logic        t11o, t11e, t12o, t12e, coil;
    logic [2:0]  loads;
    int          failures = 0;
    int          cmp_count = 0;
    output_onoff_delay #(.TICK_CYCLES(4)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .run_mode_i(run_mode_i), .func_src_i(func_src_i),
        .term11_out_o(t11o), .term11_oe_n_o(t11e), .term12_out_o(t12o),
        .term12_oe_n_o(t12e), .relay_coil_o(coil));
    ext_loads ld (.oc11_i(t11e), .oc12_i(t12e), .coil_i(coil), .on_o(loads));
    initial forever #4 clock_i = ~clock_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus_i <= '{1'b1, 1'b0, a, d};
        cyc(1);
        bus_i <= '0;
        // One idle edge so a following call never drives the bus twice at once
        cyc(1);
    endtask : wr
    // Read data stand one cycle only, so sample mid-cycle while they stand
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus_i <= '{1'b0, 1'b1, a, 32'h0};
        cyc(1);
        bus_i <= '0;
        @(negedge clock_i);
        chk(rdata_o, e);
        cyc(1);
    endtask : rd
    task automatic stop_test;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    initial begin
        #20us;
        failures++;
        stop_test();
    end
    initial begin
        cyc(12);
        sys_rst_i <= 1'b0;
        cyc(1);
        chk({29'h0, loads}, 32'h0);
        for (int i = 0; i < 6; i++) rd(6'(i * 4), 32'h0);
        $display("reset test done");
        run_mode_i <= 1'b1;
        cyc(2);
        chk({29'h0, loads}, 32'h7);
        rd(6'h24, 32'h7F);
        run_mode_i <= 1'b0;
        cyc(2);
        chk({29'h0, loads}, 32'h0);
        $display("run signal test done");
        wr(6'h10, 32'h7FF);
        rd(6'h10, 32'h3E8);
        rd(6'h28, 32'h0);
        wr(6'h00, 32'h2);
        wr(6'h04, 32'h1);
        run_mode_i <= 1'b1;
        cyc(5);
        chk({29'h0, loads}, 32'h2);
        run_mode_i <= 1'b0;
        cyc(12);
        chk({29'h0, loads}, 32'h0);
        run_mode_i <= 1'b1;
        cyc(7);
        chk({29'h0, loads}, 32'h2);
        cyc(3);
        chk({29'h0, loads}, 32'h3);
        run_mode_i <= 1'b0;
        cyc(2);
        chk({29'h0, loads}, 32'h1);
        run_mode_i <= 1'b1;
        cyc(3);
        run_mode_i <= 1'b0;
        cyc(2);
        chk({29'h0, loads}, 32'h1);
        cyc(6);
        chk({29'h0, loads}, 32'h0);
        $display("delay test done");
        wr(6'h1C, 32'h5);
        func_src_i[5] <= 1'b1;
        cyc(3);
        chk({29'h0, loads}, 32'h2);
        func_src_i[5] <= 1'b0;
        cyc(3);
        chk({29'h0, loads}, 32'h0);
        $display("select test done");
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
